// >>> hw/dcw_pkg.sv
// package: register map, fields, reset values and timing for the capture writeback block
package dcw_pkg;
  // ==========================================
  // register offsets (byte addresses)
  localparam logic [7:0] dcw_off_func_ctl = 8'h00;
  localparam logic [7:0] dcw_off_stride = 8'h04;
  localparam logic [7:0] dcw_off_surf = 8'h08;
  localparam logic [7:0] dcw_off_tail2 = 8'h0c;
  localparam logic [7:0] dcw_off_status = 8'h10;
  localparam logic [7:0] dcw_off_mask = 8'h14;
  localparam logic [7:0] dcw_off_htiming = 8'h18;
  localparam logic [7:0] dcw_off_vtiming = 8'h1c;
  // ==========================================
  // function control fields
  localparam int dcw_fc_func_en = 31;
  localparam int dcw_fc_trig_mode = 30;
  localparam int dcw_fc_start = 29;
  localparam int dcw_fc_stop = 28;
  localparam int dcw_fc_frame_lsb = 0;
  localparam int dcw_frame_w = 8;
  // status bits
  localparam int dcw_st_complete = 0;
  localparam int dcw_st_abort = 1;
  localparam int dcw_st_w = 2;
  // ==========================================
  // sizes and pointer granularity
  localparam int dcw_size_w = 13;
  localparam int dcw_addr_w = 32;
  localparam int dcw_max_h = 3840;
  localparam int dcw_max_v = 2160;
  localparam int dcw_ptr_lines = 16;
  localparam int dcw_ptr_shift = 4;
  localparam int dcw_vblank_lines = 1;
  // reset values
  localparam logic [31:0] dcw_rst_zero = 32'h0000_0000;
  localparam logic [dcw_size_w-1:0] dcw_rst_hact = 13'h0780;
  localparam logic [dcw_size_w-1:0] dcw_rst_vact = 13'h0438;
  // ==========================================
  // capture sequencer states
  typedef enum logic [2:0]
  {
    dcw_idle = 3'b000,
    dcw_vblank = 3'b001,
    dcw_active = 3'b010,
    dcw_done = 3'b011,
    dcw_off = 3'b100
  } dcw_state_e;
endpackage : dcw_pkg

// >>> hw/dcw_pix_if.sv
// interface: one formatted pixel headed for memory, with its address
`timescale 1ns/1ns
interface dcw_pix_if;
  import dcw_pkg::*;
  logic valid;
  logic [dcw_addr_w-1:0] addr;
  logic [31:0] data;
  logic line_end;
  logic frame_end;
  modport src (output valid, output addr, output data, output line_end, output frame_end);
  modport dst (input valid, input addr, input data, input line_end, input frame_end);
endinterface : dcw_pix_if

// >>> hw/dcw_addr_gen.sv
// module: places captured pixels in memory from base, stride and active sizes
`timescale 1ns/1ns
module dcw_addr_gen
  import dcw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic start,
  input wire logic abort,
  input wire logic pix_in_valid,
  input wire logic [31:0] pix_in_data,
  input wire logic [dcw_size_w-1:0] hact,
  input wire logic [dcw_size_w-1:0] vact,
  input wire logic [dcw_addr_w-1:0] base,
  input wire logic [dcw_addr_w-1:0] stride,
  output logic [dcw_size_w-1:0] line_idx,
  dcw_pix_if.src pix
);
  typedef struct packed
  {
    logic run;
    logic [dcw_size_w-1:0] x;
    logic [dcw_size_w-1:0] y;
    logic [dcw_addr_w-1:0] line_addr;
    logic valid;
    logic [dcw_addr_w-1:0] addr;
    logic [31:0] data;
    logic line_end;
    logic frame_end;
  } dcw_ag_s;
  dcw_ag_s st;
  dcw_ag_s next_st;
  logic last_x;
  logic last_y;
  // ==========================================
  // pixel placement
  always_comb
  begin
    next_st = st;
    next_st.valid = 1'b0;
    next_st.line_end = 1'b0;
    next_st.frame_end = 1'b0;
    last_x = (st.x == hact - 13'h0001);
    last_y = (st.y == vact - 13'h0001);
    if (abort)
    begin
      next_st.run = 1'b0;
    end
    else if (start)
    begin
      next_st.run = 1'b1;
      next_st.x = '0;
      next_st.y = '0;
      next_st.line_addr = base;
    end
    else if (st.run && pix_in_valid)
    begin
      next_st.valid = 1'b1;
      next_st.addr = st.line_addr + {17'h00000, st.x, 2'b00};
      next_st.data = pix_in_data;
      next_st.x = st.x + 13'h0001;
      if (last_x)
      begin
        next_st.line_end = 1'b1;
        next_st.x = '0;
        next_st.y = st.y + 13'h0001;
        next_st.line_addr = st.line_addr + stride;
        if (last_y)
        begin
          next_st.frame_end = 1'b1;
          next_st.run = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end
  assign line_idx = st.y;
  assign pix.valid = st.valid;
  assign pix.addr = st.addr;
  assign pix.data = st.data;
  assign pix.line_end = st.line_end;
  assign pix.frame_end = st.frame_end;
endmodule : dcw_addr_gen

// >>> hw/dcw_ptr_msg.sv
// module: builds encoder pointer messages with frame number and tail offset
`timescale 1ns/1ns
module dcw_ptr_msg
  import dcw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [dcw_frame_w-1:0] frame_num,
  input wire logic [dcw_size_w-1:0] tail_offset,
  input wire logic [dcw_size_w-1:0] line_idx,
  dcw_pix_if.dst pix,
  output logic msg_valid,
  output logic [dcw_frame_w-1:0] msg_frame,
  output logic [dcw_size_w-1:0] msg_tail,
  output logic msg_last
);
  typedef struct packed
  {
    logic [dcw_frame_w-1:0] frame;
    logic valid;
    logic [dcw_size_w-1:0] tail;
    logic last;
  } dcw_pm_s;
  dcw_pm_s st;
  dcw_pm_s next_st;
  logic [dcw_size_w-1:0] lines_done;
  // ==========================================
  // message every 16 written lines and at frame end
  always_comb
  begin
    next_st = st;
    next_st.valid = 1'b0;
    next_st.last = 1'b0;
    // row counter has already stepped past the finished line
    lines_done = line_idx;
    if (start)
    begin
      next_st.frame = frame_num;
    end
    if (pix.valid && pix.line_end &&
        (pix.frame_end || (lines_done[dcw_ptr_shift-1:0] == 4'h0)))
    begin
      next_st.valid = 1'b1;
      next_st.last = pix.frame_end;
      // tail counted from start of full frame
      next_st.tail = tail_offset + lines_done;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end
  assign msg_valid = st.valid;
  assign msg_frame = st.frame;
  assign msg_tail = st.tail;
  assign msg_last = st.last;
endmodule : dcw_ptr_msg

// >>> hw/dcw_capture.sv
// module: top of the writeback capture transcoder
`timescale 1ns/1ns
module dcw_capture
  import dcw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic pipe_valid,
  input wire logic [31:0] pipe_data,
  output logic pipe_ready,
  output logic mem_wr,
  output logic [dcw_addr_w-1:0] mem_addr,
  output logic [31:0] mem_data,
  output logic msg_valid,
  output logic [dcw_frame_w-1:0] msg_frame,
  output logic [dcw_size_w-1:0] msg_tail,
  output logic msg_last,
  output logic irq
);
  typedef struct packed
  {
    dcw_state_e state;
    logic func_en;
    logic trig_mode;
    logic [dcw_frame_w-1:0] frame_arm;
    logic [dcw_addr_w-1:0] stride_arm;
    logic [dcw_addr_w-1:0] surf_arm;
    logic [dcw_size_w-1:0] tail_arm;
    logic [dcw_size_w-1:0] hact_arm;
    logic [dcw_size_w-1:0] vact_arm;
    logic [dcw_frame_w-1:0] frame_live;
    logic [dcw_addr_w-1:0] stride_live;
    logic [dcw_addr_w-1:0] surf_live;
    logic [dcw_size_w-1:0] tail_live;
    logic [dcw_size_w-1:0] hact_live;
    logic [dcw_size_w-1:0] vact_live;
    logic [dcw_size_w-1:0] vb_cnt;
    logic [dcw_st_w-1:0] status;
    logic [dcw_st_w-1:0] mask;
    logic [31:0] rdata;
    logic irq;
    logic go;
    logic abort;
    logic mem_wr;
    logic [dcw_addr_w-1:0] mem_addr;
    logic [31:0] mem_data;
    logic pipe_ready;
  } dcw_top_s;
  dcw_top_s st;
  dcw_top_s next_st;
  dcw_pix_if pix ();
  logic [dcw_size_w-1:0] line_idx;
  logic wr_fc;
  logic start_req;
  logic stop_req;
  logic [dcw_st_w-1:0] set_ev;
  logic [dcw_st_w-1:0] clr_ev;
  logic capture_on;
  // ==========================================
  // pixel placement and pointer messages
  dcw_addr_gen u_addr_gen
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .start(st.go),
    .abort(st.abort),
    .pix_in_valid(pipe_valid && capture_on),
    .pix_in_data(pipe_data),
    .hact(st.hact_live),
    .vact(st.vact_live),
    .base(st.surf_live),
    .stride(st.stride_live),
    .line_idx(line_idx),
    .pix(pix)
  );
  dcw_ptr_msg u_ptr_msg
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .start(st.go),
    .frame_num(st.frame_live),
    .tail_offset(st.tail_live),
    .line_idx(line_idx),
    .pix(pix),
    .msg_valid(msg_valid),
    .msg_frame(msg_frame),
    .msg_tail(msg_tail),
    .msg_last(msg_last)
  );
  // go cycle loads the placement counters, so no pixel is taken then
  assign capture_on = (st.state == dcw_active) && !st.go;
  // ==========================================
  // register writes, sequencer, status
  always_comb
  begin
    next_st = st;
    next_st.go = 1'b0;
    next_st.abort = 1'b0;
    wr_fc = reg_wr && (reg_addr == dcw_off_func_ctl);
    start_req = wr_fc && reg_wdata[dcw_fc_start];
    stop_req = wr_fc && reg_wdata[dcw_fc_stop];
    set_ev = '0;
    clr_ev = '0;
    if (wr_fc)
    begin
      next_st.func_en = reg_wdata[dcw_fc_func_en];
      next_st.trig_mode = reg_wdata[dcw_fc_trig_mode];
      next_st.frame_arm = reg_wdata[dcw_fc_frame_lsb +: dcw_frame_w];
    end
    if (reg_wr)
    begin
      case (reg_addr)
        dcw_off_stride: next_st.stride_arm = reg_wdata;
        dcw_off_surf: next_st.surf_arm = reg_wdata;
        dcw_off_tail2: next_st.tail_arm = reg_wdata[dcw_size_w-1:0];
        dcw_off_status: clr_ev = reg_wdata[dcw_st_w-1:0];
        dcw_off_mask: next_st.mask = reg_wdata[dcw_st_w-1:0];
        dcw_off_htiming: next_st.hact_arm = reg_wdata[dcw_size_w-1:0];
        dcw_off_vtiming: next_st.vact_arm = reg_wdata[dcw_size_w-1:0];
        default: next_st.mask = next_st.mask;
      endcase
    end
    case (st.state)
      dcw_off:
      begin
        if (next_st.func_en && next_st.trig_mode)
        begin
          next_st.state = dcw_idle;
        end
      end
      dcw_idle:
      begin
        if (!next_st.func_en)
        begin
          next_st.state = dcw_off;
        end
        else if (start_req && !stop_req)
        begin
          next_st.state = dcw_vblank;
          next_st.vb_cnt = '0;
        end
      end
      dcw_vblank:
      begin
        next_st.vb_cnt = st.vb_cnt + 13'h0001;
        if (st.vb_cnt == 13'(dcw_vblank_lines - 1))
        begin
          // double-buffered update point
          next_st.frame_live = st.frame_arm;
          next_st.stride_live = st.stride_arm;
          next_st.surf_live = st.surf_arm;
          next_st.tail_live = st.tail_arm;
          next_st.hact_live = st.hact_arm;
          next_st.vact_live = st.vact_arm;
          next_st.go = 1'b1;
          next_st.state = dcw_active;
        end
      end
      dcw_active:
      begin
        if (pix.valid && pix.frame_end)
        begin
          next_st.state = dcw_done;
        end
      end
      dcw_done:
      begin
        set_ev[dcw_st_complete] = 1'b1;
        next_st.state = next_st.func_en ? dcw_idle : dcw_off;
      end
      default: next_st.state = dcw_off;
    endcase
    // stop abandons a vblank or active capture, no completion flag; in done the completion flag is still set
    if (stop_req && (st.state != dcw_off))
    begin
      next_st.abort = 1'b1;
      set_ev[dcw_st_abort] = (st.state == dcw_vblank) || (st.state == dcw_active);
      next_st.state = next_st.func_en ? dcw_idle : dcw_off;
    end
    // set wins over clear
    next_st.status = (st.status & ~clr_ev) | set_ev;
    next_st.irq = |(next_st.status & next_st.mask);
    // pixels go to memory only
    next_st.mem_wr = pix.valid;
    next_st.mem_addr = pix.addr;
    next_st.mem_data = pix.data;
    next_st.pipe_ready = (next_st.state == dcw_active) && !next_st.go;
    next_st.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        dcw_off_func_ctl: next_st.rdata = {st.func_en, st.trig_mode, 22'h000000, st.frame_arm};
        dcw_off_stride: next_st.rdata = st.stride_arm;
        dcw_off_surf: next_st.rdata = st.surf_arm;
        dcw_off_tail2: next_st.rdata = {19'h00000, st.tail_arm};
        dcw_off_status: next_st.rdata = {29'h00000000, capture_on, st.status};
        dcw_off_mask: next_st.rdata = {30'h00000000, st.mask};
        dcw_off_htiming: next_st.rdata = {19'h00000, st.hact_arm};
        dcw_off_vtiming: next_st.rdata = {19'h00000, st.vact_arm};
        default: next_st.rdata = '0;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.state <= dcw_off;
      st.hact_arm <= dcw_rst_hact;
      st.vact_arm <= dcw_rst_vact;
      st.hact_live <= dcw_rst_hact;
      st.vact_live <= dcw_rst_vact;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end
  assign reg_rdata = st.rdata;
  assign irq = st.irq;
  assign mem_wr = st.mem_wr;
  assign mem_addr = st.mem_addr;
  assign mem_data = st.mem_data;
  assign pipe_ready = st.pipe_ready;
endmodule : dcw_capture

// >>> dv/dcw_capture_props.sv
// checker: port-level timing of the capture writeback block
`timescale 1ns/1ns
module dcw_capture_props
  import dcw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic pipe_valid,
  input wire logic pipe_ready,
  input wire logic mem_wr,
  input wire logic msg_valid,
  input wire logic [dcw_frame_w-1:0] msg_frame,
  input wire logic [dcw_size_w-1:0] msg_tail,
  input wire logic msg_last,
  input wire logic irq
);
  // ==========================================
  // shadows of software writes
  logic [dcw_frame_w-1:0] fr_q;
  logic [dcw_size_w-1:0] tail_q;
  logic [dcw_size_w-1:0] vact_q;
  logic mask_q;
  logic [3:0] age;
  wire logic wr_fc = reg_wr && reg_addr == dcw_off_func_ctl;
  wire logic wr_start = wr_fc && reg_wdata[dcw_fc_start];
  wire logic acc = pipe_valid && pipe_ready;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fr_q <= '0;
      tail_q <= '0;
      vact_q <= dcw_rst_vact;
      mask_q <= 1'b0;
      age <= 4'hf;
    end
    else
    begin
      if (wr_start)
        fr_q <= reg_wdata[dcw_frame_w-1:0];
      if (reg_wr && reg_addr == dcw_off_tail2)
        tail_q <= reg_wdata[dcw_size_w-1:0];
      if (reg_wr && reg_addr == dcw_off_vtiming)
        vact_q <= reg_wdata[dcw_size_w-1:0];
      if (reg_wr && reg_addr == dcw_off_mask)
        mask_q <= reg_wdata[dcw_st_complete];
      age <= wr_start ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_done;
    msg_last && mask_q;
  endsequence
  sequence s_quiet;
    (!pipe_ready && !msg_last) [*3];
  endsequence
  a_pix_to_mem: assert property (acc |-> ##2 mem_wr)
    else $error("accepted pixel not written");
  a_mem_cause: assert property (mem_wr |-> $past(acc, 2))
    else $error("memory write without pixel");
  a_msg_after_wr: assert property (msg_valid |-> mem_wr)
    else $error("pointer message without line write");
  a_msg_frame: assert property (msg_valid |-> msg_frame == fr_q)
    else $error("wrong frame number in message");
  a_tail_offset: assert property (msg_last |-> msg_valid && msg_tail == tail_q + vact_q)
    else $error("wrong final tail");
  a_irq_done: assert property (s_done |-> ##2 irq)
    else $error("no interrupt after frame");
  a_irq_clear: assert property (reg_wr && reg_addr == dcw_off_status
    && reg_wdata[1:0] == 2'b11 && !msg_last |-> ##[1:3] !irq)
    else $error("interrupt stays after clear");
  a_stop_idle: assert property (wr_fc && reg_wdata[dcw_fc_stop] |-> ##1 s_quiet)
    else $error("capture continues after stop");
  a_trig_rise: assert property ($rose(pipe_ready) |-> age inside {[1:3]})
    else $error("capture without trigger");
endmodule : dcw_capture_props

// >>> dv/dcw_enc_model.sv
// model: encoder side collecting pointer messages
`timescale 1ns/1ns
module dcw_enc_model
  import dcw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic msg_valid,
  input wire logic [dcw_frame_w-1:0] msg_frame,
  input wire logic [dcw_size_w-1:0] msg_tail,
  input wire logic msg_last,
  output logic got_stb,
  output logic [dcw_frame_w+dcw_size_w:0] got_msg
);
  // tail counts lines from frame top, not region top
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      got_stb <= 1'b0;
      got_msg <= '0;
    end
    else
    begin
      got_stb <= msg_valid;
      if (msg_valid)
        got_msg <= {msg_frame, msg_tail, msg_last};
    end
  end
endmodule : dcw_enc_model

// >>> dv/dcw_capture_bench.sv
// bench: self-checking run of the capture writeback block
`timescale 1ns/1ns
module dcw_capture_bench;
  import dcw_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clk_en = 1'b1;
  logic pipe_valid = 1'b0;
  logic [31:0] pipe_data = '0;
  logic [31:0] reg_rdata, mem_addr, mem_data;
  logic pipe_ready, mem_wr, msg_valid, msg_last, irq, got_stb;
  logic [dcw_frame_w-1:0] msg_frame;
  logic [dcw_size_w-1:0] msg_tail;
  logic [21:0] got_msg;
  logic [63:0] q_mem[$], q_rd[$], q_msg[$];
  int n_fail = 0, num_checks = 0, seed = 9, x = 0, y = 0, npix = 0;
  int hact = 3, vact = 2, stride = 'h100, surf = 'h1000;
  bit feed = 0, rd_d = 0;
  always #25 ref_clk = ~ref_clk;
  dcw_capture u_dcw_capture (.ref_clk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .pipe_valid, .pipe_data, .pipe_ready, .mem_wr, .mem_addr, .mem_data,
    .msg_valid, .msg_frame, .msg_tail, .msg_last, .irq);
  dcw_enc_model u_dcw_enc_model (.ref_clk, .rstn, .msg_valid, .msg_frame, .msg_tail,
    .msg_last, .got_stb, .got_msg);
  // ==========================================
  // pixel source and result watcher
  always @(posedge ref_clk)
  begin
    if (pipe_valid && pipe_ready)
    begin
      q_mem.push_back({32'(surf + x * 4 + y * stride), pipe_data});
      x = (x + 1) % hact;
      y = (x == 0) ? y + 1 : y;
      npix++;
    end
    pipe_valid <= feed && npix < hact * vact && ($random(seed) & 1) != 0;
    pipe_data <= $random(seed);
    if (mem_wr === 1'b1)
      cmp({mem_addr, mem_data}, q_mem.pop_front());
    if (got_stb === 1'b1)
      cmp(64'(got_msg), q_msg.pop_front());
    if (rd_d)
      cmp(64'(reg_rdata), q_rd.pop_front());
    rd_d = reg_rd;
  end
  // ==========================================
  // tasks
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic final_report;
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q_rd.push_back(64'(e));
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic wait_hi(input bit ready);
    int i;
    for (i = 0; i < 500; i++)
    begin
      @(posedge ref_clk);
      if ((ready ? pipe_ready : msg_last) === 1'b1)
        break;
    end
    if (i == 500)
    begin
      n_fail++;
      final_report();
    end
  endtask : wait_hi
  task automatic frame(input int f, input int off, input int v, input bit busy);
    vact = v;
    x = 0;
    y = 0;
    npix = 0;
    wr(dcw_off_vtiming, 32'(v));
    wr(dcw_off_tail2, 32'(off));
    wr(dcw_off_surf, 32'(surf));
    for (int l = 16; l < v; l += 16)
      q_msg.push_back(64'({8'(f), 13'(off + l), 1'b0}));
    q_msg.push_back(64'({8'(f), 13'(off + v), 1'b1}));
    feed = 1;
    wr(dcw_off_func_ctl, 32'he000_0000 | 32'(f));
    if (busy)
    begin
      wait_hi(1);
      wr(dcw_off_func_ctl, 32'he000_0000 | 32'(f));
    end
    wait_hi(0);
    feed = 0;
  endtask : frame
  // ==========================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(dcw_off_htiming, 32'h780);
    rd(dcw_off_vtiming, 32'h438);
    rd(8'h20, 32'h0);
    rd(dcw_off_func_ctl, 32'h0);
    wr(dcw_off_htiming, 32'(hact));
    wr(dcw_off_stride, 32'(stride));
    // frozen block ignores this write
    clk_en <= 1'b0;
    wr(dcw_off_stride, 32'h0);
    clk_en <= 1'b1;
    rd(dcw_off_stride, 32'(stride));
    wr(dcw_off_mask, 32'h1);
    rd(dcw_off_mask, 32'h1);
    wr(dcw_off_func_ctl, 32'he000_0001);
    repeat (6) @(posedge ref_clk);
    cmp(64'(pipe_ready), 64'h0);
    frame(1, 0, 2, 0);
    repeat (3) @(posedge ref_clk);
    cmp(64'(irq), 64'h1);
    rd(dcw_off_status, 32'h1);
    wr(dcw_off_status, 32'h3);
    rd(dcw_off_status, 32'h0);
    cmp(64'(irq), 64'h0);
    surf = 'h1000 + 32 * stride;
    frame(2, 32, 32, 1);
    wr(dcw_off_status, 32'h3);
    wr(dcw_off_mask, 32'h0);
    surf = 'h1000;
    frame(3, 0, 2, 0);
    repeat (4) @(posedge ref_clk);
    cmp(64'(irq), 64'h0);
    rd(dcw_off_status, 32'h1);
    wr(dcw_off_status, 32'h3);
    wr(dcw_off_func_ctl, 32'he000_0004);
    wait_hi(1);
    wr(dcw_off_func_ctl, 32'hd000_0004);
    repeat (4) @(posedge ref_clk);
    rd(dcw_off_status, 32'h2);
    wr(dcw_off_func_ctl, 32'h0);
    rd(dcw_off_func_ctl, 32'h0);
    repeat (4) @(posedge ref_clk);
    cmp(64'(q_mem.size() + q_msg.size() + q_rd.size()), 64'h0);
    final_report();
  end
endmodule : dcw_capture_bench
bind dcw_capture dcw_capture_props u_dcw_capture_props (.ref_clk, .rstn, .reg_addr,
  .reg_wdata, .reg_wr, .pipe_valid, .pipe_ready, .mem_wr, .msg_valid, .msg_frame,
  .msg_tail, .msg_last, .irq);
